// [common/pdcc_defs.svh]
// register offsets, field positions, reset values and constants
`ifndef PDCC_DEFS_SVH
`define PDCC_DEFS_SVH
`define PDCC_OFS_SRC_SEL    8'h34
`define PDCC_OFS_PRESCALE   8'h35
`define PDCC_OFS_MULT_HI    8'h36
`define PDCC_OFS_FRAC_LO    8'h37
`define PDCC_OFS_INT_LO     8'h38
`define PDCC_OFS_ND_DIV     8'h39
`define PDCC_RST_SRC_SEL    8'h10
`define PDCC_RST_PRESCALE   8'h01
`define PDCC_RST_MULT_HI    8'h00
`define PDCC_RST_FRAC_LO    8'h00
`define PDCC_RST_INT_LO     8'h08
`define PDCC_RST_ND_DIV     8'h20
`define PDCC_POS_DIG_SRC    6
`define PDCC_POS_ANA_SRC    4
`define PDCC_POS_INT_HI     7
`define PDCC_POS_HALVE      6
`define PDCC_POS_FRAC_HI    0
`define PDCC_POS_N_DIV      5
`define PDCC_POS_DENSITY    2
`define PDCC_FRAC_MAX       14'h270F
`define PDCC_FRAC_SCALE     23'h002710
`endif

// [common/pdcc_pkg.sv]
// types and code decoders of the clock divider configuration
package pdcc_pkg;
  typedef enum logic [1:0] {
    DIG_PRI_BCLK = 2'h0,
    DIG_SEC_BCLK = 2'h1,
    DIG_CTRL_CLK = 2'h2,
    DIG_OSC_CLK  = 2'h3
  } pdcc_dig_src_t;
  typedef enum logic [1:0] {
    ANA_PLL_A    = 2'h0,
    ANA_PLL_B    = 2'h1,
    ANA_DIG_SRC  = 2'h2,
    ANA_PRI_LOWJ = 2'h3
  } pdcc_ana_src_t;

  function automatic logic [8:0] dec_prescale(input logic [7:0] c);
    return (c == 8'h00) ? 9'h100 : {1'b0, c};
  endfunction : dec_prescale

  function automatic logic [3:0] dec_n_div(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : {1'b0, c};
  endfunction : dec_n_div

  function automatic logic [4:0] dec_density(input logic [2:0] c);
    logic [4:0] r;
    r = 5'h01;
    if (c <= 3'h4) begin
      r = 5'(5'h01 << c);
    end
    return r;
  endfunction : dec_density
endpackage : pdcc_pkg

// [common/pdcc_cfg_if.sv]
// raw register fields to decoded divider settings
`timescale 1ns/10ps
`default_nettype none
interface pdcc_cfg_if;
  logic [7:0]  prescale_code;
  logic [8:0]  int_code;
  logic [13:0] frac_code;
  logic [2:0]  n_code;
  logic [2:0]  density_code;
  logic        auto_en;
  logic [8:0]  auto_prescale;
  logic [8:0]  auto_int;
  logic [13:0] auto_frac;
  logic [3:0]  auto_n;
  logic [4:0]  auto_density;
  logic [8:0]  prescale;
  logic [8:0]  int_mult;
  logic [13:0] frac_mult;
  logic [3:0]  n_div;
  logic [4:0]  density;
  logic [22:0] ratio_x10k;
  logic        rsvd_err;
  modport regs (output prescale_code, int_code, frac_code, n_code, density_code, auto_en,
                auto_prescale, auto_int, auto_frac, auto_n, auto_density,
                input prescale, int_mult, frac_mult, n_div, density, ratio_x10k, rsvd_err);
  modport dec  (input prescale_code, int_code, frac_code, n_code, density_code, auto_en,
                auto_prescale, auto_int, auto_frac, auto_n, auto_density,
                output prescale, int_mult, frac_mult, n_div, density, ratio_x10k, rsvd_err);
endinterface : pdcc_cfg_if
`default_nettype wire

// [src/pdcc_decode.sv]
// decodes register codes into effective divider and multiplier values
`timescale 1ns/10ps
`default_nettype none
`include "pdcc_defs.svh"
module pdcc_decode (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  pdcc_cfg_if.dec     cf
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cf.prescale  <= 9'h001;
      cf.int_mult  <= 9'h008;
      cf.frac_mult <= 14'h0000;
      cf.n_div     <= 4'h1;
      cf.density   <= 5'h01;
    end else if (cf.auto_en) begin
      cf.prescale  <= cf.auto_prescale;
      cf.int_mult  <= cf.auto_int;
      cf.frac_mult <= cf.auto_frac;
      cf.n_div     <= cf.auto_n;
      cf.density   <= cf.auto_density;
    end else begin
      cf.prescale  <= pdcc_pkg::dec_prescale(cf.prescale_code);
      cf.int_mult  <= cf.int_code;
      cf.frac_mult <= cf.frac_code;
      cf.n_div     <= pdcc_pkg::dec_n_div(cf.n_code);
      cf.density   <= pdcc_pkg::dec_density(cf.density_code);
    end
  end

  // ratio and reserved code flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cf.ratio_x10k <= 23'h013880;
      cf.rsvd_err   <= 1'b0;
    end else begin
      cf.ratio_x10k <= 23'(cf.int_mult) * `PDCC_FRAC_SCALE + 23'(cf.frac_mult);
      cf.rsvd_err   <= !cf.auto_en && ((cf.int_code == 9'h000) ||
                       (cf.frac_code > `PDCC_FRAC_MAX) || (cf.density_code > 3'h4));
    end
  end
endmodule : pdcc_decode
`default_nettype wire

// [src/pdcc_top.sv]
// clock source selection and loop/ratio divider configuration
`timescale 1ns/10ps
`default_nettype none
`include "pdcc_defs.svh"
module pdcc_top (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic        I_REG_WR_EN,
  input  wire logic        I_REG_RD_EN,
  input  wire logic [7:0]  I_REG_WDATA,
  output logic      [7:0]  O_REG_RDATA,
  input  wire logic        I_PRI_BCLK,
  input  wire logic        I_SEC_BCLK,
  input  wire logic        I_CTRL_CLK,
  input  wire logic        I_OSC_CLK,
  input  wire logic        I_PLL_CLK,
  input  wire logic        I_AUTO_DETECT_EN,
  input  wire logic [8:0]  I_AUTO_PRESCALE,
  input  wire logic [8:0]  I_AUTO_INT_MULT,
  input  wire logic [13:0] I_AUTO_FRAC_MULT,
  input  wire logic [3:0]  I_AUTO_N_DIV,
  input  wire logic [4:0]  I_AUTO_DENSITY_DIV,
  output logic             O_DIG_SRC_CLK,
  output logic             O_ANA_SRC_CLK,
  output logic      [8:0]  O_PRESCALE_DIV,
  output logic      [8:0]  O_INT_MULT,
  output logic      [13:0] O_FRAC_MULT,
  output logic             O_HALVE_EN,
  output logic      [3:0]  O_N_DIV,
  output logic      [4:0]  O_DENSITY_DIV,
  output logic      [22:0] O_RATIO_X10K,
  output logic             O_CFG_RSVD_ERR,
  output logic             O_PRESCALE_TICK,
  output logic             O_N_TICK,
  output logic             O_DENSITY_TICK
);
  logic [7:0] src_sel_ff;
  logic [7:0] prescale_ff;
  logic [7:0] mult_hi_ff;
  logic [7:0] frac_lo_ff;
  logic [7:0] int_lo_ff;
  logic [7:0] nd_ff;
  logic       dig_prev_ff;
  logic       ana_prev_ff;
  logic [8:0] pre_cnt_ff;
  logic       half_ff;
  logic [3:0] n_cnt_ff;
  logic [4:0] dens_cnt_ff;
  logic       nxt_dig_src;
  logic       nxt_ana_src;
  logic       dig_rise;
  logic       ana_rise;
  logic       pre_wrap;
  logic       n_wrap;
  pdcc_pkg::pdcc_dig_src_t dig_sel;
  pdcc_pkg::pdcc_ana_src_t ana_sel;

  pdcc_cfg_if cf ();

  //////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      src_sel_ff  <= `PDCC_RST_SRC_SEL;
      prescale_ff <= `PDCC_RST_PRESCALE;
      mult_hi_ff  <= `PDCC_RST_MULT_HI;
      frac_lo_ff  <= `PDCC_RST_FRAC_LO;
      int_lo_ff   <= `PDCC_RST_INT_LO;
      nd_ff       <= `PDCC_RST_ND_DIV;
    end else if (I_REG_WR_EN) begin
      case (I_REG_ADDR)
        `PDCC_OFS_SRC_SEL:  src_sel_ff  <= I_REG_WDATA;
        `PDCC_OFS_PRESCALE: prescale_ff <= I_REG_WDATA;
        `PDCC_OFS_MULT_HI:  mult_hi_ff  <= I_REG_WDATA;
        `PDCC_OFS_FRAC_LO:  frac_lo_ff  <= I_REG_WDATA;
        `PDCC_OFS_INT_LO:   int_lo_ff   <= I_REG_WDATA;
        `PDCC_OFS_ND_DIV:   nd_ff       <= I_REG_WDATA;
        default: ;
      endcase
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD_EN) begin
      case (I_REG_ADDR)
        `PDCC_OFS_SRC_SEL:  O_REG_RDATA <= src_sel_ff;
        `PDCC_OFS_PRESCALE: O_REG_RDATA <= prescale_ff;
        `PDCC_OFS_MULT_HI:  O_REG_RDATA <= mult_hi_ff;
        `PDCC_OFS_FRAC_LO:  O_REG_RDATA <= frac_lo_ff;
        `PDCC_OFS_INT_LO:   O_REG_RDATA <= int_lo_ff;
        `PDCC_OFS_ND_DIV:   O_REG_RDATA <= nd_ff;
        default:            O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // field extraction into the decoder
  assign cf.prescale_code = prescale_ff;
  assign cf.int_code      = {mult_hi_ff[`PDCC_POS_INT_HI], int_lo_ff};
  assign cf.frac_code     = {mult_hi_ff[`PDCC_POS_FRAC_HI+5:`PDCC_POS_FRAC_HI],
                             frac_lo_ff};
  assign cf.n_code        = nd_ff[`PDCC_POS_N_DIV+2:`PDCC_POS_N_DIV];
  assign cf.density_code  = nd_ff[`PDCC_POS_DENSITY+2:`PDCC_POS_DENSITY];
  assign cf.auto_en       = I_AUTO_DETECT_EN;
  assign cf.auto_prescale = I_AUTO_PRESCALE;
  assign cf.auto_int      = I_AUTO_INT_MULT;
  assign cf.auto_frac     = I_AUTO_FRAC_MULT;
  assign cf.auto_n        = I_AUTO_N_DIV;
  assign cf.auto_density  = I_AUTO_DENSITY_DIV;

  pdcc_decode u_decode (
    .i_clk (I_CORE_CLK),
    .i_rst (I_RST),
    .cf    (cf.dec)
  );

  assign O_PRESCALE_DIV = cf.prescale;
  assign O_INT_MULT     = cf.int_mult;
  assign O_FRAC_MULT    = cf.frac_mult;
  assign O_N_DIV        = cf.n_div;
  assign O_DENSITY_DIV  = cf.density;
  assign O_RATIO_X10K   = cf.ratio_x10k;
  assign O_CFG_RSVD_ERR = cf.rsvd_err;
  assign O_HALVE_EN     = mult_hi_ff[`PDCC_POS_HALVE];

  //////////////////////////////////////////////////////////////////////////////
  // source clock selection
  assign dig_sel = pdcc_pkg::pdcc_dig_src_t'(src_sel_ff[`PDCC_POS_DIG_SRC+1:`PDCC_POS_DIG_SRC]);
  assign ana_sel = pdcc_pkg::pdcc_ana_src_t'(src_sel_ff[`PDCC_POS_ANA_SRC+1:`PDCC_POS_ANA_SRC]);

  always_comb begin
    case (dig_sel)
      pdcc_pkg::DIG_PRI_BCLK: nxt_dig_src = I_PRI_BCLK;
      pdcc_pkg::DIG_SEC_BCLK: nxt_dig_src = I_SEC_BCLK;
      pdcc_pkg::DIG_CTRL_CLK: nxt_dig_src = I_CTRL_CLK;
      pdcc_pkg::DIG_OSC_CLK:  nxt_dig_src = I_OSC_CLK;
      default:                nxt_dig_src = I_PRI_BCLK;
    endcase
  end

  always_comb begin
    case (ana_sel)
      pdcc_pkg::ANA_PLL_A:    nxt_ana_src = I_PLL_CLK;
      pdcc_pkg::ANA_PLL_B:    nxt_ana_src = I_PLL_CLK;
      pdcc_pkg::ANA_DIG_SRC:  nxt_ana_src = nxt_dig_src;
      pdcc_pkg::ANA_PRI_LOWJ: nxt_ana_src = I_PRI_BCLK;
      default:                nxt_ana_src = I_PLL_CLK;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_DIG_SRC_CLK <= 1'b0;
      O_ANA_SRC_CLK <= 1'b0;
      dig_prev_ff   <= 1'b0;
      ana_prev_ff   <= 1'b0;
    end else begin
      O_DIG_SRC_CLK <= nxt_dig_src;
      O_ANA_SRC_CLK <= nxt_ana_src;
      dig_prev_ff   <= O_DIG_SRC_CLK;
      ana_prev_ff   <= O_ANA_SRC_CLK;
    end
  end

  assign dig_rise = O_DIG_SRC_CLK & ~dig_prev_ff;
  assign ana_rise = O_ANA_SRC_CLK & ~ana_prev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // prescale divider with optional halving
  assign pre_wrap = dig_rise && (pre_cnt_ff >= 9'(cf.prescale - 9'h001));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pre_cnt_ff      <= 9'h000;
      half_ff         <= 1'b0;
      O_PRESCALE_TICK <= 1'b0;
    end else begin
      O_PRESCALE_TICK <= pre_wrap && (!O_HALVE_EN || half_ff);
      if (pre_wrap) begin
        pre_cnt_ff <= 9'h000;
        half_ff    <= O_HALVE_EN ? ~half_ff : 1'b0;
      end else if (dig_rise) begin
        pre_cnt_ff <= pre_cnt_ff + 9'h001;
      end
    end
  end

  // n divider then density divider
  assign n_wrap = ana_rise && (n_cnt_ff >= 4'(cf.n_div - 4'h1));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      n_cnt_ff <= 4'h0;
      O_N_TICK <= 1'b0;
    end else begin
      O_N_TICK <= n_wrap;
      if (n_wrap) begin
        n_cnt_ff <= 4'h0;
      end else if (ana_rise) begin
        n_cnt_ff <= n_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      dens_cnt_ff    <= 5'h00;
      O_DENSITY_TICK <= 1'b0;
    end else begin
      O_DENSITY_TICK <= 1'b0;
      if (O_N_TICK) begin
        if (dens_cnt_ff >= 5'(cf.density - 5'h01)) begin
          dens_cnt_ff    <= 5'h00;
          O_DENSITY_TICK <= 1'b1;
        end else begin
          dens_cnt_ff <= dens_cnt_ff + 5'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_manual_prev;
    !I_AUTO_DETECT_EN ##1 1'b1;
  endsequence

  a_dig_src_pick: assert property (
    O_DIG_SRC_CLK == (($past(src_sel_ff[7:6]) == 2'h0) ? $past(I_PRI_BCLK) :
                      ($past(src_sel_ff[7:6]) == 2'h1) ? $past(I_SEC_BCLK) :
                      ($past(src_sel_ff[7:6]) == 2'h2) ? $past(I_CTRL_CLK) :
                      $past(I_OSC_CLK)))
    else $error("digital source mux wrong");

  a_ana_src_pick: assert property (
    O_ANA_SRC_CLK == (($past(src_sel_ff[5:4]) == 2'h3) ? $past(I_PRI_BCLK) :
                      ($past(src_sel_ff[5:4]) == 2'h2) ? $past(nxt_dig_src) :
                      $past(I_PLL_CLK)))
    else $error("analog source mux wrong");

  a_prescale_decode: assert property (s_manual_prev |->
    O_PRESCALE_DIV == (($past(prescale_ff) == 8'h00) ? 9'h100 : {1'b0, $past(prescale_ff)}))
    else $error("prescale decode wrong");

  a_int_mult_join: assert property (s_manual_prev |->
    O_INT_MULT == {$past(mult_hi_ff[7]), $past(int_lo_ff)})
    else $error("integer multiplier join wrong");

  a_frac_mult_join: assert property (s_manual_prev |->
    O_FRAC_MULT == {$past(mult_hi_ff[5:0]), $past(frac_lo_ff)})
    else $error("fraction multiplier join wrong");

  a_halve_skip: assert property (pre_wrap && O_HALVE_EN && !half_ff |=> !O_PRESCALE_TICK)
    else $error("halving let first wrap tick");

  a_halve_pass: assert property (pre_wrap && O_HALVE_EN && half_ff |=> O_PRESCALE_TICK)
    else $error("halving dropped second wrap tick");

  a_n_div_decode: assert property (s_manual_prev |->
    O_N_DIV == (($past(nd_ff[7:5]) == 3'h0) ? 4'h8 : {1'b0, $past(nd_ff[7:5])}))
    else $error("n divider decode wrong");

  a_density_decode: assert property (s_manual_prev ##0 ($past(nd_ff[4:2]) == 3'h4) |->
    O_DENSITY_DIV == 5'h10)
    else $error("density code 4 not 16");

  a_auto_override: assert property (I_AUTO_DETECT_EN ##1 1'b1 |->
    O_PRESCALE_DIV == $past(I_AUTO_PRESCALE) && O_N_DIV == $past(I_AUTO_N_DIV))
    else $error("auto detection values not used");

  a_ratio_value: assert property (
    O_RATIO_X10K == 23'($past(O_INT_MULT)) * `PDCC_FRAC_SCALE + 23'($past(O_FRAC_MULT)))
    else $error("loop ratio wrong");
endmodule : pdcc_top
`default_nettype wire

// [dv/tb_pdcc_top.sv]
// self-checking testbench of the clock divider configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_pdcc_top;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        wr_en    = 1'b0;
  logic        rd_en    = 1'b0;
  logic [7:0]  wdata    = 8'h00;
  logic [4:0]  srcs     = 5'h00;
  logic        auto_en  = 1'b0;
  logic [8:0]  a_pre    = 9'h000;
  logic [8:0]  a_int    = 9'h000;
  logic [13:0] a_frac   = 14'h0000;
  logic [3:0]  a_n      = 4'h0;
  logic [4:0]  a_den    = 5'h00;
  logic [7:0]  rdata;
  logic        dig_clk, ana_clk, halve, rsvd, pre_tick, n_tick, den_tick;
  logic [8:0]  pre_div, int_mult;
  logic [13:0] frac_mult;
  logic [3:0]  n_div;
  logic [4:0]  den_div;
  logic [22:0] ratio;
  int          err_total = 0;
  int          samples_checked = 0;
  int          n_pre, n_nt, n_dt;

  always #5 core_clk = ~core_clk;

  pdcc_top uut (.I_CORE_CLK(core_clk), .I_RST(rst), .I_REG_ADDR(reg_addr),
    .I_REG_WR_EN(wr_en), .I_REG_RD_EN(rd_en), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .I_PRI_BCLK(srcs[0]), .I_SEC_BCLK(srcs[1]), .I_CTRL_CLK(srcs[2]), .I_OSC_CLK(srcs[3]),
    .I_PLL_CLK(srcs[4]), .I_AUTO_DETECT_EN(auto_en), .I_AUTO_PRESCALE(a_pre),
    .I_AUTO_INT_MULT(a_int), .I_AUTO_FRAC_MULT(a_frac), .I_AUTO_N_DIV(a_n),
    .I_AUTO_DENSITY_DIV(a_den), .O_DIG_SRC_CLK(dig_clk), .O_ANA_SRC_CLK(ana_clk),
    .O_PRESCALE_DIV(pre_div), .O_INT_MULT(int_mult), .O_FRAC_MULT(frac_mult),
    .O_HALVE_EN(halve), .O_N_DIV(n_div), .O_DENSITY_DIV(den_div), .O_RATIO_X10K(ratio),
    .O_CFG_RSVD_ERR(rsvd), .O_PRESCALE_TICK(pre_tick), .O_N_TICK(n_tick),
    .O_DENSITY_TICK(den_tick));

  // tick counters
  always @(posedge core_clk) begin
    if (rst) begin
      n_pre <= 0;
      n_nt  <= 0;
      n_dt  <= 0;
    end else begin
      n_pre <= n_pre + int'(pre_tick);
      n_nt  <= n_nt + int'(n_tick);
      n_dt  <= n_dt + int'(den_tick);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [22:0] got, input logic [22:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic do_reset();
    @(posedge core_clk) rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    wdata    <= d;
    wr_en    <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    rd_en    <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    chk_reg(rdata, exp);
  endtask : rd_chk

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk) srcs <= 5'h11;
      repeat (3) @(posedge core_clk);
      srcs <= 5'h00;
      repeat (3) @(posedge core_clk);
    end
    settle();
  endtask : pulses

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] tab [6] = '{8'h10, 8'h01, 8'h00, 8'h00, 8'h08, 8'h20};
    #1;
    chk_reg(rdata, 8'h00);
    for (int i = 0; i < 6; i++) rd_chk(8'h34 + 8'(i), tab[i]);
    chk_val(pre_div, 23'd1);
    chk_val(int_mult, 23'd8);
    chk_val(ratio, 23'd80000);
    chk_val(halve, 23'd0);
    chk_val(n_div, 23'd1);
    chk_val(den_div, 23'd1);
    wr(8'h3A, 8'hFF);
    rd_chk(8'h3A, 8'h00);
    rd_chk(8'h35, 8'h01);
  endtask : t_reset

  task automatic t_prescale();
    logic [7:0] codes [4] = '{8'h00, 8'h02, 8'hFF, 8'h01};
    foreach (codes[i]) begin
      wr(8'h35, codes[i]);
      settle();
      chk_val(pre_div, (codes[i] == 8'h00) ? 23'd256 : 23'(codes[i]));
    end
  endtask : t_prescale

  task automatic t_mult();
    wr(8'h36, 8'hA7);
    wr(8'h37, 8'h0F);
    wr(8'h38, 8'hFF);
    settle();
    chk_val(int_mult, 23'd511);
    chk_val(frac_mult, 23'd9999);
    chk_val(ratio, 23'd511 * 23'd10000 + 23'd9999);
    chk_val(rsvd, 23'd0);
    chk_val(halve, 23'd0);
    wr(8'h36, 8'h00);
    wr(8'h38, 8'h00);
    settle();
    chk_val(int_mult, 23'd0);
    chk_val(rsvd, 23'd1);
    wr(8'h38, 8'h01);
    wr(8'h36, 8'h3F);
    wr(8'h37, 8'hFF);
    settle();
    chk_val(rsvd, 23'd1);
    wr(8'h36, 8'h40);
    wr(8'h37, 8'h00);
    settle();
    chk_val(halve, 23'd1);
    chk_val(ratio, 23'd10000);
    rd_chk(8'h36, 8'h40);
    wr(8'h36, 8'h00);
    settle();
    chk_val(rsvd, 23'd0);
  endtask : t_mult

  task automatic t_n_ratio_divider();
    for (int i = 0; i < 8; i++) begin
      wr(8'h39, {3'(i), 3'(i), 2'b00});
      settle();
      chk_val(n_div, (i == 0) ? 23'd8 : 23'(i));
      chk_val(den_div, (i < 5) ? 23'(1 << i) : 23'd1);
      chk_val(rsvd, 23'(i > 4));
    end
  endtask : t_n_ratio_divider

  task automatic t_auto();
    @(posedge core_clk);
    auto_en <= 1'b1;
    a_pre   <= 9'h0C0;
    a_int   <= 9'h123;
    a_frac  <= 14'h1234;
    a_n     <= 4'h5;
    a_den   <= 5'h10;
    settle();
    chk_val(pre_div, 23'h0C0);
    chk_val(int_mult, 23'h123);
    chk_val(frac_mult, 23'h1234);
    chk_val(n_div, 23'h5);
    chk_val(den_div, 23'h10);
    chk_val(rsvd, 23'd0);
    @(posedge core_clk) auto_en <= 1'b0;
    settle();
    chk_val(n_div, 23'd7);
    chk_val(rsvd, 23'd1);
    wr(8'h39, 8'h20);
  endtask : t_auto

  task automatic t_src();
    int ai;
    for (int d = 0; d < 4; d++) begin
      for (int a = 0; a < 4; a++) begin
        wr(8'h34, {2'(d), 2'(a), 4'h0});
        ai = (a < 2) ? 4 : ((a == 2) ? d : 0);
        @(posedge core_clk) srcs <= 5'(5'h01 << ai);
        settle();
        chk_val(ana_clk, 23'd1);
        chk_val(dig_clk, 23'(d == ai));
        @(posedge core_clk) srcs <= 5'(~(5'h01 << ai));
        settle();
        chk_val(ana_clk, 23'd0);
        chk_val(dig_clk, 23'(d != ai));
      end
    end
    @(posedge core_clk) srcs <= 5'h00;
    wr(8'h34, 8'h10);
  endtask : t_src

  task automatic t_ticks();
    int p0;
    do_reset();
    wr(8'h35, 8'h02);
    wr(8'h39, {3'h2, 3'h1, 2'b00});
    pulses(8);
    chk_val(23'(n_pre), 23'd4);
    chk_val(23'(n_nt), 23'd4);
    chk_val(23'(n_dt), 23'd2);
    wr(8'h36, 8'h40);
    p0 = n_pre;
    pulses(8);
    chk_val(23'(n_pre - p0), 23'd2);
  endtask : t_ticks

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_reset();
    t_prescale();
    t_mult();
    t_n_ratio_divider();
    t_auto();
    t_src();
    t_ticks();
    stop_test();
  end

  initial begin
    #400000;
    err_total++;
    stop_test();
  end
endmodule : tb_pdcc_top
`default_nettype wire
